// ==== core/scw_pkg.sv ====
// Constants, field layout and types shared by the configuration word block.
package scw_pkg;

  // Register port.
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam logic [15:0] SYSCFG_ADDR = 16'hFF12;
  localparam logic [15:0] SYSCFG_RESET = 16'h0000;
  localparam logic [15:0] RDATA_IDLE = 16'h0000;

  // Field positions inside the configuration word.
  localparam int unsigned B_SHARE = 0;
  localparam int unsigned B_VISIBLE = 1;
  localparam int unsigned B_PERIPH_EN = 2;
  localparam int unsigned B_BIDIR_RST = 3;
  localparam int unsigned B_OSC_MON_DIS = 4;
  localparam int unsigned B_PWD_WAKE = 5;
  localparam int unsigned B_CS_TIMING = 6;
  localparam int unsigned B_WR_SPLIT = 7;
  localparam int unsigned B_CLK_OUT_EN = 8;
  localparam int unsigned B_HIGH_BYTE_DIS = 9;
  localparam int unsigned B_INT_MEM_EN = 10;
  localparam int unsigned B_SEG_DIS = 11;
  localparam int unsigned B_FLASH_SEG = 12;

  // Reset configuration sampled from port zero.
  localparam int unsigned P0_WRC_BIT = 5;
  localparam int unsigned P0_BUSTYPE_LSB = 6;
  localparam logic [1:0] BUSTYPE_8BIT_DEMUX = 2'h0;
  localparam logic [1:0] BUSTYPE_8BIT_MUX = 2'h2;

  // Pin groups.
  localparam int unsigned CS_N = 5;
  localparam int unsigned EXT_INT_N = 8;

  // Timing: 40 MHz system clock, one clock phase unit is half a period.
  localparam int unsigned CLK_PERIOD_PS = 25000;
  localparam int unsigned OSC_IDLE_MIN_US = 1;
  localparam int unsigned OSC_CNT_W = 8;
  localparam logic [OSC_CNT_W-1:0] OSC_IDLE_CYCLES =
    OSC_CNT_W'((OSC_IDLE_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned RST_DRIVE_TCL = 1024;
  localparam int unsigned TCL_PER_CYCLE = 2;
  localparam int unsigned RST_CNT_W = 10;
  localparam logic [RST_CNT_W-1:0] RST_DRIVE_CYCLES =
    RST_CNT_W'((RST_DRIVE_TCL + TCL_PER_CYCLE - 1) / TCL_PER_CYCLE);

  // Power-down controller states.
  typedef enum logic [1:0]
  {
    PD_RUN = 2'h1,
    PD_DOWN = 2'h2
  } scw_pd_t;

endpackage

// ==== core/scw_mon_if.sv ====
// Carrier between the configuration word and its oscillator monitor.
`timescale 1ns/100ps
interface scw_mon_if;
  logic enable;
  logic crystal;
  logic fail;
  modport ctl (output enable, output crystal, input fail);
  modport mon (input enable, input crystal, output fail);
endinterface

// ==== core/scw_osc_monitor.sv ====
// Crystal activity monitor: flags a crystal input that stops toggling.
`timescale 1ns/100ps
module scw_osc_monitor
  import scw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  scw_mon_if.mon mon
);

  typedef struct packed {
    logic prev;
    logic [OSC_CNT_W-1:0] cnt;
    logic fail;
  } scw_mon_state_t;

  scw_mon_state_t st_r;
  scw_mon_state_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.prev = mon.crystal;
    if (!mon.enable || (mon.crystal != st_r.prev))
    begin
      st_nxt.cnt = '0;
      st_nxt.fail = 1'b0;
    end
    else if (st_r.cnt < OSC_IDLE_CYCLES)
    begin
      st_nxt.cnt = st_r.cnt + OSC_CNT_W'(1);
    end
    else
    begin
      // A full microsecond without any edge counts as a dead crystal.
      st_nxt.fail = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      st_r <= '0;
    end
    else if (clk_en)
    begin
      st_r <= st_nxt;
    end
  end

  assign mon.fail = st_r.fail;

endmodule

// ==== core/scw_system_config.sv ====
// System configuration word: register, reset straps and the logic it steers.
//
// What this block does
// - Writes to the configuration word are ignored once end-of-init has run.
// - Memory enable, high-byte disable and write split load from straps at reset.
// - Share bit set lets an external master reach on-chip peripherals during hold.
// - Visible bit set reproduces on-chip peripheral accesses on external pins.
// - Peripheral enable clear blocks all on-chip peripheral and extension RAM access.
// - Bidirectional reset bit set drives reset pin low 1024 phase units per sequence.
// - Monitor on and PLL bypassed: 1 us without crystal edges selects PLL base.
// - Monitor off and PLL bypassed: crystal clocks the CPU, PLL powered down.
// - Wake select clear: power-down needs NMI low, only reset leaves it.
// - Wake select set: enter with enabled fast pins idle, leave on one asserted.
// - Chip selects change one system clock after latch strobe rise, or on it.
// - Write split bit is inverse strap; set makes write and high-byte pins split strobes.
// - Clock output enable drives the system clock image on the clock pin.
// - High-byte disable set stops driving the high-byte enable pin unless write split is set.
// - Internal memory enable clear routes internal memory accesses externally.
// - Segmentation disable set saves only the instruction pointer on interrupts.
// - Flash segment select maps internal flash to segment 0 or segment 1.
`timescale 1ns/100ps
module scw_system_config
  import scw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic end_init_instruction,
  input wire logic [DATA_W-1:0] port_zero,
  input wire logic external_access_pin_n,
  input wire logic hold_mode,
  input wire logic onchip_req,
  input wire logic ext_master_req,
  input wire logic imem_area_req,
  output logic onchip_periph_grant,
  output logic onchip_visible,
  output logic ext_master_grant,
  output logic imem_route_external,
  input wire logic reset_seq_start,
  input wire logic ext_reset_req,
  output logic reset_in_pin_o,
  output logic reset_in_pin_oe,
  input wire logic crystal_input,
  input wire logic pll_bypass,
  output logic cpu_clk_from_pll,
  output logic pll_power_on,
  input wire logic powerdown_instruction,
  input wire logic nmi_pin_n,
  input wire logic [EXT_INT_N-1:0] fast_ext_int_pins,
  input wire logic [EXT_INT_N-1:0] fast_ext_int_enable,
  output logic powerdown_active,
  input wire logic ale,
  input wire logic [CS_N-1:0] chip_select_req,
  output logic [CS_N-1:0] chip_selects,
  input wire logic bus_wr_n,
  input wire logic bus_bhe_n,
  input wire logic bus_wrl_n,
  input wire logic bus_wrh_n,
  output logic write_pin_n,
  output logic high_byte_pin_n,
  output logic high_byte_pin_oe,
  output logic clock_out_pin,
  output logic clock_out_oe,
  output logic segmentation_disable,
  output logic flash_segment_select
);

  typedef struct packed {
    logic [DATA_W-1:0] cfg;
    logic locked;
    logic strap_done;
    logic [DATA_W-1:0] rdata;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic rst_oe;
    scw_pd_t pd;
    logic ale_d;
    logic [CS_N-1:0] cs_latch;
    logic cs_pend;
    logic [CS_N-1:0] cs_out;
    logic wr_pin;
    logic bhe_pin;
    logic bhe_oe;
    logic clk_out;
    logic clk_oe;
    logic periph_grant;
    logic visible;
    logic ext_grant;
    logic imem_ext;
    logic pll_sel;
    logic pll_on;
    logic rst_pin_lvl;
    logic pd_active;
  } scw_state_t;

  scw_state_t st_r;
  scw_state_t st_nxt;
  scw_mon_if mon_if ();

  // Single decode of the register address, shared by the read and write paths.
  function automatic logic cfg_hit(input logic [ADDR_W-1:0] addr);
    cfg_hit = (addr == SYSCFG_ADDR);
  endfunction

  // True when any enabled fast external interrupt pin is asserted.
  function automatic logic wake_pin_seen(input logic [EXT_INT_N-1:0] pins,
                                         input logic [EXT_INT_N-1:0] ena);
    wake_pin_seen = |(pins & ena);
  endfunction

  // The crystal is sampled as a plain synchronous input, so edges faster than half the clock are lost.
  scw_osc_monitor u_osc_monitor (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .mon(mon_if.mon)
  );

  assign mon_if.enable = pll_bypass & ~st_r.cfg[B_OSC_MON_DIS];
  assign mon_if.crystal = crystal_input;

  always_comb
  begin
    st_nxt = st_r;

    // Straps are caught on the first enabled cycle after reset release, so the
    // flops never take a port value under reset.
    if (!st_r.strap_done)
    begin
      st_nxt.strap_done = 1'b1;
      st_nxt.cfg[B_INT_MEM_EN] = external_access_pin_n;
      st_nxt.cfg[B_HIGH_BYTE_DIS] =
        (port_zero[P0_BUSTYPE_LSB +: 2] == BUSTYPE_8BIT_DEMUX) ||
        (port_zero[P0_BUSTYPE_LSB +: 2] == BUSTYPE_8BIT_MUX);
      st_nxt.cfg[B_WR_SPLIT] = ~port_zero[P0_WRC_BIT];
    end
    else if (reg_wr && cfg_hit(reg_addr) && !st_r.locked)
    begin
      st_nxt.cfg = reg_wdata;
    end

    // The lock is never cleared here: only a reset reopens the word, so software
    // cannot undo its own end-of-init.
    if (end_init_instruction)
    begin
      st_nxt.locked = 1'b1;
    end

    // Read data stand for exactly the cycle after the strobe.
    st_nxt.rdata = RDATA_IDLE;
    if (reg_rd && cfg_hit(reg_addr))
    begin
      st_nxt.rdata = st_r.cfg;
    end

    // On-chip peripheral bus gating. The grants are registered, so a decision
    // trails its request by one cycle and the requester must hold until then.
    st_nxt.periph_grant = onchip_req & st_r.cfg[B_PERIPH_EN];
    st_nxt.visible = onchip_req & st_r.cfg[B_PERIPH_EN] & st_r.cfg[B_VISIBLE];
    st_nxt.ext_grant = ext_master_req & hold_mode & st_r.cfg[B_SHARE] &
                       st_r.cfg[B_PERIPH_EN];
    st_nxt.imem_ext = imem_area_req & ~st_r.cfg[B_INT_MEM_EN];

    // Reset pin driver: a software or watchdog sequence leaves the pin alone
    // unless the bidirectional mode is on.
    if (reset_seq_start && st_r.cfg[B_BIDIR_RST])
    begin
      st_nxt.rst_oe = 1'b1;
      st_nxt.rst_cnt = RST_DRIVE_CYCLES;
    end
    else if (st_r.rst_oe)
    begin
      if (st_r.rst_cnt == RST_CNT_W'(1))
      begin
        st_nxt.rst_oe = 1'b0;
        st_nxt.rst_cnt = '0;
      end
      else
      begin
        st_nxt.rst_cnt = st_r.rst_cnt - RST_CNT_W'(1);
      end
    end

    // The reset pin is only ever pulled low; its enable alone decides whether
    // the device drives it.
    st_nxt.rst_pin_lvl = 1'b0;

    // Clock source selection. Without the bypass the PLL always runs; the
    // monitor only matters while the crystal feeds the CPU directly.
    if (!pll_bypass)
    begin
      st_nxt.pll_sel = 1'b1;
      st_nxt.pll_on = 1'b1;
    end
    else if (st_r.cfg[B_OSC_MON_DIS])
    begin
      st_nxt.pll_sel = 1'b0;
      st_nxt.pll_on = 1'b0;
    end
    else
    begin
      st_nxt.pll_sel = mon_if.fail;
      st_nxt.pll_on = 1'b1;
    end

    // Power-down entry and exit. With wake select clear only an external reset
    // ends power-down; the NMI pin plays no part in the exit.
    case (st_r.pd)
      PD_RUN:
      begin
        if (powerdown_instruction)
        begin
          if (!st_r.cfg[B_PWD_WAKE] && !nmi_pin_n)
          begin
            st_nxt.pd = PD_DOWN;
          end
          else if (st_r.cfg[B_PWD_WAKE] &&
                   !wake_pin_seen(fast_ext_int_pins, fast_ext_int_enable))
          begin
            st_nxt.pd = PD_DOWN;
          end
        end
      end
      PD_DOWN:
      begin
        if (ext_reset_req)
        begin
          st_nxt.pd = PD_RUN;
        end
        else if (st_r.cfg[B_PWD_WAKE] &&
                 wake_pin_seen(fast_ext_int_pins, fast_ext_int_enable))
        begin
          st_nxt.pd = PD_RUN;
        end
      end
      default:
      begin
        st_nxt.pd = PD_RUN;
      end
    endcase

    // The power-down flag is a flop of its own, so the output never passes
    // through a compare of the state code.
    st_nxt.pd_active = (st_nxt.pd == PD_DOWN);

    // Chip selects: one phase unit is taken as one system clock here, since
    // finer steps cannot be resolved on a single clock edge.
    // A strobe rise before the pending copy lands would overwrite the latch.
    st_nxt.ale_d = ale;
    st_nxt.cs_pend = 1'b0;
    if (ale && !st_r.ale_d)
    begin
      if (st_r.cfg[B_CS_TIMING])
      begin
        st_nxt.cs_out = chip_select_req;
      end
      else
      begin
        st_nxt.cs_latch = chip_select_req;
        st_nxt.cs_pend = 1'b1;
      end
    end
    if (st_r.cs_pend)
    begin
      st_nxt.cs_out = st_r.cs_latch;
    end

    // Write strobe pins. In split mode both pins carry strobes, so the
    // high-byte pin is driven even when the high-byte disable is set.
    if (st_r.cfg[B_WR_SPLIT])
    begin
      st_nxt.wr_pin = bus_wrl_n;
      st_nxt.bhe_pin = bus_wrh_n;
      st_nxt.bhe_oe = 1'b1;
    end
    else
    begin
      st_nxt.wr_pin = bus_wr_n;
      st_nxt.bhe_pin = bus_bhe_n;
      st_nxt.bhe_oe = ~st_r.cfg[B_HIGH_BYTE_DIS];
    end

    // Clock output: a toggle image of the system clock, released when off.
    // Half the system rate is the finest image a single-edge design can make.
    if (st_r.cfg[B_CLK_OUT_EN])
    begin
      st_nxt.clk_out = ~st_r.clk_out;
      st_nxt.clk_oe = 1'b1;
    end
    else
    begin
      st_nxt.clk_out = 1'b0;
      st_nxt.clk_oe = 1'b0;
    end
  end

  // Reset does not wait for the clock enable, so a frozen block still leaves reset known.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      st_r <= '0;
      st_r.cfg <= SYSCFG_RESET;
      st_r.pd <= PD_RUN;
      st_r.pll_on <= 1'b1;
      st_r.pll_sel <= 1'b1;
      st_r.wr_pin <= 1'b1;
      st_r.bhe_pin <= 1'b1;
      st_r.ale_d <= 1'b1;
    end
    else if (clk_en)
    begin
      st_r <= st_nxt;
    end
  end

  // Every pin and flag below comes straight from a register, so none glitches.
  assign reg_rdata = st_r.rdata;
  assign onchip_periph_grant = st_r.periph_grant;
  assign onchip_visible = st_r.visible;
  assign ext_master_grant = st_r.ext_grant;
  assign imem_route_external = st_r.imem_ext;
  assign reset_in_pin_o = st_r.rst_pin_lvl;
  assign reset_in_pin_oe = st_r.rst_oe;
  assign cpu_clk_from_pll = st_r.pll_sel;
  assign pll_power_on = st_r.pll_on;
  assign powerdown_active = st_r.pd_active;
  assign chip_selects = st_r.cs_out;
  assign write_pin_n = st_r.wr_pin;
  assign high_byte_pin_n = st_r.bhe_pin;
  assign high_byte_pin_oe = st_r.bhe_oe;
  assign clock_out_pin = st_r.clk_out;
  assign clock_out_oe = st_r.clk_oe;
  assign segmentation_disable = st_r.cfg[B_SEG_DIS];
  assign flash_segment_select = st_r.cfg[B_FLASH_SEG];

endmodule

// ==== bench/scw_system_config_sva.sv ====
// Port-level assertions for the system configuration word.
`timescale 1ns/100ps
module scw_system_config_sva
  import scw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic onchip_req,
  input wire logic onchip_periph_grant,
  input wire logic onchip_visible,
  input wire logic hold_mode,
  input wire logic ext_master_req,
  input wire logic ext_master_grant,
  input wire logic reset_seq_start,
  input wire logic reset_in_pin_oe,
  input wire logic powerdown_instruction,
  input wire logic powerdown_active,
  input wire logic ale,
  input wire logic [CS_N-1:0] chip_selects,
  input wire logic pll_power_on,
  input wire logic cpu_clk_from_pll
);
  logic ale_r;
  logic ale_rise;
  logic [9:0] oe_cnt_r;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  assign ale_rise = ale & ~ale_r;
  // A new reset sequence restarts the drive window, so the count restarts with it.
  always_ff @(posedge clk_sys)
  begin
    ale_r <= reset_n & ale;
    oe_cnt_r <= (!reset_n || reset_seq_start || !reset_in_pin_oe) ? 10'h000 : oe_cnt_r + 10'h001;
  end
  property p_rdata_idle; !reg_rd |=> reg_rdata == RDATA_IDLE; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_visible; onchip_visible |-> onchip_periph_grant && $past(onchip_req); endproperty
  a_visible: assert property (p_visible) else $error("visible without grant");
  property p_periph; onchip_periph_grant |-> $past(onchip_req); endproperty
  a_periph: assert property (p_periph) else $error("grant without request");
  property p_share; ext_master_grant |-> $past(hold_mode) && $past(ext_master_req); endproperty
  a_share: assert property (p_share) else $error("external grant outside hold");
  property p_rst_len; $fell(reset_in_pin_oe) |-> oe_cnt_r == 10'h200; endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pin drive length wrong");
  property p_rst_cause; $rose(reset_in_pin_oe) |-> $past(reset_seq_start); endproperty
  a_rst_cause: assert property (p_rst_cause) else $error("reset pin driven unasked");
  property p_pd_enter; $rose(powerdown_active) |-> $past(powerdown_instruction); endproperty
  a_pd_enter: assert property (p_pd_enter) else $error("power-down without instruction");
  property p_cs; $changed(chip_selects) |-> $past(ale_rise) || $past(ale_rise, 2); endproperty
  a_cs: assert property (p_cs) else $error("chip selects moved off strobe");
  property p_pll_off; !pll_power_on |-> !cpu_clk_from_pll; endproperty
  a_pll_off: assert property (p_pll_off) else $error("clock from stopped pll");
endmodule
bind scw_system_config scw_system_config_sva scw_system_config_sva_inst (.*);

// ==== bench/scw_system_config_tb.sv ====
// Self-checking bench for the system configuration word.
`timescale 1ns/100ps
module scw_system_config_tb
  import scw_pkg::*;
;
  logic clk_sys = 1'b0, reset_n = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic end_init_instruction = 1'b0, hold_mode = 1'b0, onchip_req = 1'b1, ale = 1'b0;
  logic ext_master_req = 1'b1, imem_area_req = 1'b1, reset_seq_start = 1'b0;
  logic ext_reset_req = 1'b0, crystal_input = 1'b0, pll_bypass = 1'b0, nmi_pin_n = 1'b1;
  logic powerdown_instruction = 1'b0, external_access_pin_n = 1'b1;
  logic bus_wr_n = 1'b1, bus_bhe_n = 1'b1, bus_wrl_n = 1'b1, bus_wrh_n = 1'b1;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, port_zero = 16'h0000;
  logic [7:0] fast_ext_int_pins = 8'h00, fast_ext_int_enable = 8'h00;
  logic [4:0] chip_select_req = 5'h00;
  logic [15:0] reg_rdata, rv, d;
  logic onchip_periph_grant, onchip_visible, ext_master_grant, imem_route_external;
  logic reset_in_pin_o, reset_in_pin_oe, cpu_clk_from_pll, pll_power_on, powerdown_active;
  logic write_pin_n, high_byte_pin_n, high_byte_pin_oe, clock_out_pin, clock_out_oe;
  logic segmentation_disable, flash_segment_select;
  logic [4:0] chip_selects, cs_old;
  logic [2:0] e;
  integer fails = 0, n_checks = 0, seed = 79, k, cnt;

  scw_system_config scw_system_config_inst (.*);

  initial
  begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  function automatic logic [15:0] strap_exp(input logic [15:0] p0, input logic ea_n);
    strap_exp = {5'h00, ea_n, ~p0[6], 1'b0, ~p0[5], 7'h00};
  endfunction

  // Pin that the device does not drive is expected high; the check forces its seen level high too.
  function automatic logic [2:0] strobe_exp(input logic split, input logic hbdis,
    input logic [3:0] s);
    strobe_exp = split ? {s[2], s[3], 1'b1} : {s[0], s[1] | hbdis, ~hbdis};
  endfunction

  task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] y);
    n_checks++;
    if (y !== x)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, x, y);
    end
  endtask

  task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= w;
    reg_rd <= ~w;
    @(posedge clk_sys);
    {reg_wr, reg_rd} <= 2'h0;
    #1 d = reg_rdata;
  endtask

  task automatic cfg(input logic [15:0] v);
    bus(1'b1, SYSCFG_ADDR, v);
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic pulse_pd();
    @(posedge clk_sys);
    powerdown_instruction <= 1'b1;
    @(posedge clk_sys);
    powerdown_instruction <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic rst_count();
    reset_seq_start <= 1'b1;
    @(posedge clk_sys);
    reset_seq_start <= 1'b0;
    cnt = 0;
    repeat (600)
    begin
      #1 cnt = cnt + (reset_in_pin_oe === 1'b1 && reset_in_pin_o === 1'b0);
      @(posedge clk_sys);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    tally_and_finish();
  end

  initial
  begin
    do_reset();
    bus(1'b0, SYSCFG_ADDR, 16'h0000);
    chk("strap_word", strap_exp(16'h0000, 1'b1), d);
    for (k = 0; k < 6; k++)
    begin
      rv = 16'($random(seed));
      bus(1'b1, SYSCFG_ADDR, rv);
      bus(1'b0, SYSCFG_ADDR, 16'h0000);
      chk("word_rw", rv, d);
    end
    bus(1'b1, 16'hFF14, ~rv);
    bus(1'b0, 16'hFF14, 16'h0000);
    chk("unmapped_rd", RDATA_IDLE, d);
    bus(1'b0, SYSCFG_ADDR, 16'h0000);
    chk("unmapped_wr", rv, d);
    $display("test word access done");
    for (k = 0; k < 16; k++)
    begin
      @(posedge clk_sys);
      hold_mode <= k[3];
      cfg({3'h0, k[2], k[1], k[0], 7'h00, k[2], k[1], k[0]});
      rv = {10'h000, k[2], k[2] & k[1], k[2] & k[0] & k[3], ~k[0], k[1], k[2]};
      #1 d = {10'h000, onchip_periph_grant, onchip_visible, ext_master_grant,
        imem_route_external, segmentation_disable, flash_segment_select};
      chk("steering", rv, d);
    end
    $display("test steering done");
    cfg(16'h0008);
    rst_count();
    chk("rst_drive", 16'h0200, 16'(cnt));
    cfg(16'h0000);
    rst_count();
    chk("rst_nodrive", 16'h0000, 16'(cnt));
    pulse_pd();
    chk("pd_nmi_high", 16'h0000, {15'h0000, powerdown_active});
    @(posedge clk_sys);
    nmi_pin_n <= 1'b0;
    fast_ext_int_enable <= 8'hFF;
    fast_ext_int_pins <= 8'h01;
    pulse_pd();
    chk("pd_nmi_low", 16'h0001, {15'h0000, powerdown_active});
    @(posedge clk_sys);
    ext_reset_req <= 1'b1;
    @(posedge clk_sys);
    ext_reset_req <= 1'b0;
    @(posedge clk_sys);
    #1 chk("pd_reset_exit", 16'h0000, {15'h0000, powerdown_active});
    cfg(16'h0020);
    rv = 16'($random(seed));
    fast_ext_int_enable <= rv[7:0] | 8'h01;
    pulse_pd();
    chk("pd_pin_busy", 16'h0000, {15'h0000, powerdown_active});
    @(posedge clk_sys);
    fast_ext_int_pins <= ~(rv[7:0] | 8'h01);
    pulse_pd();
    chk("pd_pins_idle", 16'h0001, {15'h0000, powerdown_active});
    @(posedge clk_sys);
    fast_ext_int_pins <= 8'h01;
    repeat (2) @(posedge clk_sys);
    #1 chk("pd_pin_wake", 16'h0000, {15'h0000, powerdown_active});
    $display("test reset pin and power-down done");
    cs_old = 5'h00;
    for (k = 0; k < 4; k++)
    begin
      cfg({9'h000, k[0], 6'h00});
      rv = 16'($random(seed));
      ale <= 1'b1;
      chip_select_req <= rv[4:0];
      @(posedge clk_sys);
      #1 chk("cs_first", 16'(k[0] ? rv[4:0] : cs_old), 16'(chip_selects));
      @(posedge clk_sys);
      ale <= 1'b0;
      #1 chk("cs_second", 16'(rv[4:0]), 16'(chip_selects));
      cs_old = rv[4:0];
    end
    for (k = 0; k < 8; k++)
    begin
      cfg({6'h00, k[1], 1'b0, k[0], 7'h00});
      rv = 16'($random(seed));
      {bus_wrh_n, bus_wrl_n, bus_bhe_n, bus_wr_n} <= rv[3:0];
      e = strobe_exp(k[0], k[1], rv[3:0]);
      repeat (2) @(posedge clk_sys);
      #1 d = {13'h0000, write_pin_n, high_byte_pin_n | ~e[0], high_byte_pin_oe};
      chk("strobes", {13'h0000, e}, d);
    end
    cfg(16'h0100);
    #1 rv[0] = clock_out_pin;
    @(posedge clk_sys);
    #1 chk("clock_out_pin", {14'h0000, ~rv[0], 1'b1}, {14'h0000, clock_out_pin, clock_out_oe});
    @(posedge clk_sys);
    clk_en <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk("clk_en_freeze", {15'h0000, rv[0]}, {15'h0000, clock_out_pin});
    @(posedge clk_sys);
    clk_en <= 1'b1;
    cfg(16'h0000);
    #1 chk("clock_out_pin_off", 16'h0000, {15'h0000, clock_out_oe});
    $display("test pins done");
    @(posedge clk_sys);
    pll_bypass <= 1'b1;
    cfg(16'h0010);
    #1 chk("osc_off", 16'h0000, {14'h0000, pll_power_on, cpu_clk_from_pll});
    cfg(16'h0000);
    repeat (20)
    begin
      @(posedge clk_sys);
      crystal_input <= ~crystal_input;
    end
    repeat (30) @(posedge clk_sys);
    #1 chk("osc_quiet_short", 16'h0000, {15'h0000, cpu_clk_from_pll});
    repeat (20) @(posedge clk_sys);
    #1 chk("osc_quiet_long", 16'h0001, {15'h0000, cpu_clk_from_pll});
    @(posedge clk_sys);
    pll_bypass <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 chk("pll_normal", 16'h0003, {14'h0000, pll_power_on, cpu_clk_from_pll});
    $display("test oscillator done");
    rv = 16'($random(seed));
    bus(1'b1, SYSCFG_ADDR, rv);
    @(posedge clk_sys);
    end_init_instruction <= 1'b1;
    @(posedge clk_sys);
    end_init_instruction <= 1'b0;
    bus(1'b1, SYSCFG_ADDR, ~rv);
    bus(1'b0, SYSCFG_ADDR, 16'h0000);
    chk("locked", rv, d);
    @(posedge clk_sys);
    port_zero <= 16'($random(seed));
    external_access_pin_n <= rv[4];
    do_reset();
    bus(1'b0, SYSCFG_ADDR, 16'h0000);
    chk("strap_word_2", strap_exp(port_zero, rv[4]), d);
    bus(1'b1, SYSCFG_ADDR, rv);
    bus(1'b0, SYSCFG_ADDR, 16'h0000);
    chk("unlocked", rv, d);
    $display("test lock and straps done");
    tally_and_finish();
  end
endmodule
